//--- usw_pkg.sv
package usw_pkg;

  // register byte offsets on the AXI4-Lite port
  localparam int                AXI_ADDR_W      = 8;
  localparam logic [7:0]        OFS_STATUS2     = 8'h00;
  localparam logic [7:0]        OFS_IRQ_STATUS  = 8'h04;
  localparam logic [7:0]        OFS_IRQ_MASK    = 8'h08;
  localparam logic [7:0]        OFS_CONTROL     = 8'h0c;

  // second status word layout
  localparam int                ST_W            = 16;
  localparam int                BIT_ON_BATTERY  = 0;
  localparam int                BIT_KEYPRESS    = 2;
  localparam int                BIT_SHUTDOWN    = 3;
  localparam int                BIT_ON_AC       = 5;
  localparam int                BIT_OVERLOAD    = 6;
  localparam int                BIT_FLOAT_DONE  = 7;
  localparam int                BIT_EQ_WAIT     = 8;
  localparam int                BIT_TEST_PASS   = 9;
  localparam int                BIT_SYS_DOWN    = 10;
  localparam int                BIT_LINE_RANGE  = 11;
  localparam int                BIT_DELAYED     = 12;
  localparam int                BIT_OUT_LOW     = 15;
  localparam logic [15:0]       ST_RSVD_MASK    = 16'h6012;
  // all sensed levels low means running on ac, so bit 5 starts set
  localparam logic [15:0]       ST_RESET        = 16'h0020;

  // condition pins, in this order inside the synchroniser vector
  localparam int                PIN_W           = 11;

  // interrupt status and mask layout
  localparam int                IRQ_W           = 4;
  localparam int                IRQ_LINE_LOSS   = 0;
  localparam int                IRQ_OVERLOAD    = 1;
  localparam int                IRQ_OUT_LOW     = 2;
  localparam int                IRQ_NOTICE_DONE = 3;
  localparam logic [3:0]        IRQ_RESET       = 4'h0;
  localparam logic [3:0]        MASK_RESET      = 4'h0;

  // control register
  localparam int                CTRL_NOTICE_EN  = 0;
  localparam logic [0:0]        CTRL_RESET      = 1'h1;

  localparam logic [1:0]        RESP_OKAY       = 2'h0;
  localparam logic [1:0]        RESP_SLVERR     = 2'h2;

  // serial timing: 8 ns clock, 104167 ns bit time (about 9600 baud)
  localparam int                CLK_PERIOD_NS   = 8;
  localparam int                BIT_TIME_NS     = 104167;
  localparam int                BIT_CYCLES      = BIT_TIME_NS / CLK_PERIOD_NS;

  // unsolicited notice, sent as 8N1 characters
  localparam int                MSG_LEN         = 20;
  localparam logic [4:0]        MSG_LAST        = 5'h13;

  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} usw_tx_type;

  function automatic logic [7:0] usw_msg_char(input logic [4:0] idx);
    logic [7:0] c;
    c = 8'h00;
    case (idx)
      5'h00: c = 8'h4c;
      5'h01: c = 8'h69;
      5'h02: c = 8'h6e;
      5'h03: c = 8'h65;
      5'h04: c = 8'h20;
      5'h05: c = 8'h4c;
      5'h06: c = 8'h6f;
      5'h07: c = 8'h73;
      5'h08: c = 8'h73;
      5'h09: c = 8'h20;
      5'h0a: c = 8'h44;
      5'h0b: c = 8'h65;
      5'h0c: c = 8'h74;
      5'h0d: c = 8'h65;
      5'h0e: c = 8'h63;
      5'h0f: c = 8'h74;
      5'h10: c = 8'h65;
      5'h11: c = 8'h64;
      5'h12: c = 8'h0d;
      5'h13: c = 8'h0a;
      default: c = 8'h00;
    endcase
    return c;
  endfunction : usw_msg_char

endpackage : usw_pkg

//--- usw_pin_sync.sv
`timescale 1ns/100ps
module usw_pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             mclk_in,
  input  wire logic             rst_b_in,
  input  wire logic [WIDTH-1:0] pins_in,
  output logic      [WIDTH-1:0] level_out
);

  logic [WIDTH-1:0] s1;
  logic [WIDTH-1:0] s2;
  logic [WIDTH-1:0] s3;

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else begin
      s1 <= pins_in;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // a bit moves only when stages two and three agree, which drops single-cycle glitches
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      level_out <= '0;
    end else begin
      level_out <= (s2 & ~(s2 ^ s3)) | (level_out & (s2 ^ s3));
    end
  end

endmodule : usw_pin_sync

//--- usw_status_word2_reporter.sv
// Implementation choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/100ps
module usw_status_word2_reporter
  import usw_pkg::*;
#(
  parameter int BIT_CYC = BIT_CYCLES
) (
  input  wire logic                  mclk_in,
  input  wire logic                  rst_b_in,
  input  wire logic                  on_battery_in,
  input  wire logic                  keypress_pend_in,
  input  wire logic                  shutdown_cmd_in,
  input  wire logic                  overload_150_in,
  input  wire logic                  float_expired_in,
  input  wire logic                  equalize_wait_in,
  input  wire logic                  selftest_pass_in,
  input  wire logic                  system_down_in,
  input  wire logic                  line_out_range_in,
  input  wire logic                  delayed_event_in,
  input  wire logic                  output_low_in,
  input  wire logic [AXI_ADDR_W-1:0] s_axi_awaddr_in,
  input  wire logic                  s_axi_awvalid_in,
  output logic                       s_axi_awready_out,
  input  wire logic [31:0]           s_axi_wdata_in,
  input  wire logic [3:0]            s_axi_wstrb_in,
  input  wire logic                  s_axi_wvalid_in,
  output logic                       s_axi_wready_out,
  output logic [1:0]                 s_axi_bresp_out,
  output logic                       s_axi_bvalid_out,
  input  wire logic                  s_axi_bready_in,
  input  wire logic [AXI_ADDR_W-1:0] s_axi_araddr_in,
  input  wire logic                  s_axi_arvalid_in,
  output logic                       s_axi_arready_out,
  output logic [31:0]                s_axi_rdata_out,
  output logic [1:0]                 s_axi_rresp_out,
  output logic                       s_axi_rvalid_out,
  input  wire logic                  s_axi_rready_in,
  output logic                       irq_out,
  output logic                       uart_txd_out
);

  localparam int              CNT_W    = $clog2(BIT_CYC + 1);
  localparam logic [CNT_W-1:0] BIT_LAST = CNT_W'(BIT_CYC - 1);

  logic [PIN_W-1:0]      pins;
  logic [PIN_W-1:0]      lvl;
  logic [ST_W-1:0]       status2;
  logic [ST_W-1:0]       next_status2;
  logic [IRQ_W-1:0]      irq_stat;
  logic [IRQ_W-1:0]      irq_mask;
  logic [IRQ_W-1:0]      irq_evt;
  logic [IRQ_W-1:0]      irq_clr;
  logic                  notice_en;
  logic                  batt_q;
  logic                  ovl_q;
  logic                  low_q;
  logic                  loss_evt;
  logic                  notice_pend;
  logic                  notice_go;
  logic                  notice_done;
  usw_tx_type            tx_state;
  logic [CNT_W-1:0]      baud_cnt;
  logic                  bit_tick;
  logic [4:0]            chr_idx;
  logic [2:0]            bit_idx;
  logic [7:0]            tx_byte;
  logic [AXI_ADDR_W-1:0] wr_addr;
  logic [31:0]           wr_data;
  logic                  wr_strb0;
  logic                  wr_go;
  logic                  wr_hit;

  // sensing circuits are asynchronous to the core clock
  assign pins = {output_low_in, delayed_event_in, line_out_range_in, system_down_in, selftest_pass_in,
                 equalize_wait_in, float_expired_in, overload_150_in, shutdown_cmd_in, keypress_pend_in,
                 on_battery_in};

  usw_pin_sync #(
    .WIDTH     (PIN_W)
  ) u_pin_sync (
    .mclk_in   (mclk_in),
    .rst_b_in  (rst_b_in),
    .pins_in   (pins),
    .level_out (lvl)
  );

  always_comb begin
    next_status2                 = '0;
    next_status2[BIT_ON_BATTERY] = lvl[0];
    next_status2[BIT_KEYPRESS]   = lvl[1];
    next_status2[BIT_SHUTDOWN]   = lvl[2];
    next_status2[BIT_ON_AC]      = ~lvl[0];
    next_status2[BIT_OVERLOAD]   = lvl[3];
    next_status2[BIT_FLOAT_DONE] = lvl[4];
    next_status2[BIT_EQ_WAIT]    = lvl[5];
    next_status2[BIT_TEST_PASS]  = lvl[6];
    next_status2[BIT_SYS_DOWN]   = lvl[7];
    next_status2[BIT_LINE_RANGE] = lvl[8];
    next_status2[BIT_DELAYED]    = lvl[9];
    next_status2[BIT_OUT_LOW]    = lvl[10];
  end

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      status2 <= ST_RESET;
    end else begin
      status2 <= next_status2;
    end
  end

  // edge history for the interrupt events and the line loss notice
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      batt_q <= 1'b0;
      ovl_q  <= 1'b0;
      low_q  <= 1'b0;
    end else begin
      batt_q <= lvl[0];
      ovl_q  <= lvl[3];
      low_q  <= lvl[10];
    end
  end

  assign loss_evt = lvl[0] & ~batt_q;
  always_comb begin
    irq_evt                  = '0;
    irq_evt[IRQ_LINE_LOSS]   = loss_evt;
    irq_evt[IRQ_OVERLOAD]    = lvl[3] & ~ovl_q;
    irq_evt[IRQ_OUT_LOW]     = lvl[10] & ~low_q;
    irq_evt[IRQ_NOTICE_DONE] = notice_done;
  end

  // line loss notice transmitter
  assign notice_go   = (tx_state == TX_IDLE) && notice_pend && notice_en;
  assign bit_tick    = (tx_state != TX_IDLE) && (baud_cnt == BIT_LAST);
  assign notice_done = bit_tick && (tx_state == TX_STOP) && (chr_idx == MSG_LAST);

  // a loss seen while the notice is still going out queues one more copy
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      notice_pend <= 1'b0;
    end else begin
      notice_pend <= (loss_evt & notice_en) | (notice_pend & ~notice_go);
    end
  end

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      baud_cnt <= '0;
    end else if (tx_state == TX_IDLE || bit_tick) begin
      baud_cnt <= '0;
    end else begin
      baud_cnt <= baud_cnt + 1'b1;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tx_state <= TX_IDLE;
      chr_idx  <= '0;
      bit_idx  <= '0;
      tx_byte  <= '0;
    end else begin
      case (tx_state)
        TX_IDLE: begin
          if (notice_go) begin
            tx_state <= TX_START;
            chr_idx  <= '0;
            tx_byte  <= usw_msg_char(5'h00);
          end
        end
        TX_START: begin
          if (bit_tick) begin
            tx_state <= TX_DATA;
            bit_idx  <= '0;
          end
        end
        TX_DATA: begin
          if (bit_tick) begin
            bit_idx <= bit_idx + 1'b1;
            if (bit_idx == 3'h7) begin
              tx_state <= TX_STOP;
            end
          end
        end
        TX_STOP: begin
          if (bit_tick) begin
            if (chr_idx == MSG_LAST) begin
              tx_state <= TX_IDLE;
            end else begin
              tx_state <= TX_START;
              chr_idx  <= chr_idx + 1'b1;
              tx_byte  <= usw_msg_char(chr_idx + 1'b1);
            end
          end
        end
        default: tx_state <= TX_IDLE;
      endcase
    end
  end

  // lsb first, line idles high
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      uart_txd_out <= 1'b1;
    end else begin
      case (tx_state)
        TX_START: uart_txd_out <= 1'b0;
        TX_DATA:  uart_txd_out <= tx_byte[bit_idx];
        default:  uart_txd_out <= 1'b1;
      endcase
    end
  end

  // address and data are taken in either order; the write acts one cycle after both are held
  assign wr_go  = !s_axi_awready_out && !s_axi_wready_out && !s_axi_bvalid_out;
  assign wr_hit = (wr_addr[7:2] == OFS_STATUS2[7:2]) || (wr_addr[7:2] == OFS_IRQ_STATUS[7:2]) ||
                  (wr_addr[7:2] == OFS_IRQ_MASK[7:2]) || (wr_addr[7:2] == OFS_CONTROL[7:2]);

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s_axi_awready_out <= 1'b1;
      wr_addr           <= '0;
    end else if (s_axi_awvalid_in && s_axi_awready_out) begin
      s_axi_awready_out <= 1'b0;
      wr_addr           <= s_axi_awaddr_in;
    end else if (s_axi_bvalid_out && s_axi_bready_in) begin
      s_axi_awready_out <= 1'b1;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s_axi_wready_out <= 1'b1;
      wr_data          <= '0;
      wr_strb0         <= 1'b0;
    end else if (s_axi_wvalid_in && s_axi_wready_out) begin
      s_axi_wready_out <= 1'b0;
      wr_data          <= s_axi_wdata_in;
      wr_strb0         <= s_axi_wstrb_in[0];
    end else if (s_axi_bvalid_out && s_axi_bready_in) begin
      s_axi_wready_out <= 1'b1;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out  <= RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid_out <= 1'b1;
      s_axi_bresp_out  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bvalid_out && s_axi_bready_in) begin
      s_axi_bvalid_out <= 1'b0;
    end
  end

  // writes to the status word are accepted and ignored: it follows the sensed levels only
  assign irq_clr = (wr_go && wr_strb0 && wr_addr[7:2] == OFS_IRQ_STATUS[7:2]) ? wr_data[IRQ_W-1:0] : '0;

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      irq_mask  <= MASK_RESET;
      notice_en <= CTRL_RESET[0];
    end else if (wr_go && wr_strb0) begin
      if (wr_addr[7:2] == OFS_IRQ_MASK[7:2]) begin
        irq_mask <= wr_data[IRQ_W-1:0];
      end
      if (wr_addr[7:2] == OFS_CONTROL[7:2]) begin
        notice_en <= wr_data[CTRL_NOTICE_EN];
      end
    end
  end

  // an event in the cycle of its clear still sets the flag
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      irq_stat <= IRQ_RESET;
    end else begin
      irq_stat <= (irq_stat & ~irq_clr) | irq_evt;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(irq_stat & irq_mask);
    end
  end

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s_axi_arready_out <= 1'b1;
      s_axi_rvalid_out  <= 1'b0;
      s_axi_rdata_out   <= '0;
      s_axi_rresp_out   <= RESP_OKAY;
    end else if (s_axi_arvalid_in && s_axi_arready_out) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out  <= 1'b1;
      s_axi_rresp_out   <= RESP_OKAY;
      case (s_axi_araddr_in[7:2])
        OFS_STATUS2[7:2]:    s_axi_rdata_out <= {16'h0000, status2};
        OFS_IRQ_STATUS[7:2]: s_axi_rdata_out <= {28'h0000000, irq_stat};
        OFS_IRQ_MASK[7:2]:   s_axi_rdata_out <= {28'h0000000, irq_mask};
        OFS_CONTROL[7:2]:    s_axi_rdata_out <= {31'h00000000, notice_en};
        default: begin
          s_axi_rdata_out <= '0;
          s_axi_rresp_out <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid_out && s_axi_rready_in) begin
      s_axi_rvalid_out  <= 1'b0;
      s_axi_arready_out <= 1'b1;
    end
  end

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_b_in);
  sequence s_notice_kick;
    (tx_state == TX_IDLE) && notice_pend && notice_en;
  endsequence
  sequence s_frame_open;
    (tx_state == TX_START) ##1 !uart_txd_out;
  endsequence
  a_batt_follows_pin: assert property ($stable(on_battery_in) [*6] |-> status2[BIT_ON_BATTERY] == on_battery_in)
    else $error("battery bit does not follow its pin");
  a_ac_bit_inverse: assert property ($stable(on_battery_in) [*6] |-> status2[BIT_ON_AC] != on_battery_in)
    else $error("ac bit is not the inverse of battery bit");
  a_flags_follow_pins: assert property ($stable(pins) [*6] |->
    {status2[15], status2[12:6], status2[3:2]} == pins[10:1])
    else $error("status flags do not follow their pins");
  a_reserved_read_zero: assert property ((status2 & ST_RSVD_MASK) == 16'h0000)
    else $error("reserved status bit is set");
  a_loss_queues_notice: assert property (loss_evt && notice_en |=> notice_pend || tx_state == TX_START)
    else $error("line loss did not queue a notice");
  a_notice_starts_frame: assert property (s_notice_kick |=> s_frame_open)
    else $error("notice did not start with a start bit");
  a_notice_first_char: assert property (s_notice_kick |=> tx_byte == 8'h4c && chr_idx == 5'h00)
    else $error("notice does not begin with its first character");
  a_loss_sets_irq: assert property (loss_evt |=> irq_stat[IRQ_LINE_LOSS])
    else $error("line loss event lost from interrupt status");
  a_irq_follows_mask: assert property (|(irq_stat & irq_mask) |=> irq_out)
    else $error("unmasked interrupt not raised");
  a_read_answer_next: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
    else $error("read answer not given in one cycle");
  a_bresp_held: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
    else $error("write response dropped before taken");
endmodule : usw_status_word2_reporter

//--- usw_host_rx.sv
`timescale 1ns/100ps
module usw_host_rx #(
  parameter int BIT_CYC = 8
) (
  input  wire logic       mclk_in,
  input  wire logic       txd_in,
  output logic [7:0]      rx_buf_out [0:31],
  output logic [5:0]      rx_count_out,
  output logic [5:0]      frame_err_out
);
  logic [7:0] shift;

  // samples mid-bit like a host port; a glitch shorter than half a bit is dropped
  initial begin
    rx_count_out  = 6'h00;
    frame_err_out = 6'h00;
    forever begin
      @(negedge txd_in);
      repeat (BIT_CYC / 2) @(posedge mclk_in);
      if (txd_in === 1'b0) begin
        for (int i = 0; i < 8; i++) begin
          repeat (BIT_CYC) @(posedge mclk_in);
          shift[i] = txd_in;
        end
        repeat (BIT_CYC) @(posedge mclk_in);
        if (txd_in !== 1'b1) begin
          frame_err_out = frame_err_out + 6'h01;
        end
        rx_buf_out[rx_count_out[4:0]] = shift;
        rx_count_out = rx_count_out + 6'h01;
      end
    end
  end
endmodule : usw_host_rx

//--- usw_status_word2_reporter_bench.sv
`timescale 1ns/100ps
module usw_status_word2_reporter_bench
  import usw_pkg::*;
;
  localparam int BC = 8;
  logic        mclk_in = 1'b0;
  logic        rst_b_in = 1'b0;
  logic [10:0] pins = 11'h000;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, irq, txd;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [7:0]  rx_buf [0:31];
  logic [5:0]  rx_count, frame_err;
  int          n_mismatch = 0;
  int          n_checks = 0;

  always #4 mclk_in = ~mclk_in;

  usw_status_word2_reporter #(.BIT_CYC(BC)) i_dut (
    .mclk_in(mclk_in), .rst_b_in(rst_b_in),
    .on_battery_in(pins[0]), .keypress_pend_in(pins[1]), .shutdown_cmd_in(pins[2]),
    .overload_150_in(pins[3]), .float_expired_in(pins[4]), .equalize_wait_in(pins[5]),
    .selftest_pass_in(pins[6]), .system_down_in(pins[7]), .line_out_range_in(pins[8]),
    .delayed_event_in(pins[9]), .output_low_in(pins[10]),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .irq_out(irq), .uart_txd_out(txd)
  );

  usw_host_rx #(.BIT_CYC(BC)) i_host (
    .mclk_in(mclk_in), .txd_in(txd), .rx_buf_out(rx_buf),
    .rx_count_out(rx_count), .frame_err_out(frame_err)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic give_verdict();
    if (n_mismatch == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : give_verdict

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done  = 1'b0;
    @(posedge mclk_in);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge mclk_in);
      if (awvalid && awready === 1'b1) begin aw_done = 1'b1; awvalid <= 1'b0; end
      if (wvalid && wready === 1'b1) begin w_done = 1'b1; wvalid <= 1'b0; end
    end
    // bready rises only once bvalid shows, so the slave must hold its answer a cycle
    while (bvalid !== 1'b1) @(posedge mclk_in);
    bready <= 1'b1;
    @(posedge mclk_in);
    r = bresp;
    bready <= 1'b0;
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge mclk_in);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do @(posedge mclk_in); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge mclk_in);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axi_read

  task automatic rd_check(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    axi_read(a, d, r);
    check({30'h0, r}, {30'h0, RESP_OKAY});
    check(d, exp);
  endtask : rd_check

  function automatic logic [31:0] exp_status(input logic [10:0] p);
    logic [31:0] e;
    e = 32'h0;
    e[0] = p[0]; e[2] = p[1]; e[3] = p[2]; e[5] = ~p[0]; e[6] = p[3]; e[7] = p[4];
    e[8] = p[5]; e[9] = p[6]; e[10] = p[7]; e[11] = p[8]; e[12] = p[9]; e[15] = p[10];
    return e;
  endfunction : exp_status

  task automatic test_reset_values();
    check({31'h0, irq}, 32'h0);
    check({31'h0, txd}, 32'h1);
    rd_check(OFS_STATUS2, 32'h0000_0020);
    rd_check(OFS_IRQ_MASK, 32'h0);
    rd_check(OFS_CONTROL, 32'h1);
  endtask : test_reset_values

  // each condition alone, then all together: reserved bits must stay clear
  task automatic test_status_walk();
    logic [10:0] p;
    logic [1:0]  r;
    axi_write(OFS_CONTROL, 32'h0, r);
    for (int i = 0; i <= 11; i++) begin
      p = (i == 11) ? 11'h7ff : (11'h001 << i);
      @(posedge mclk_in);
      pins <= p;
      repeat (10) @(posedge mclk_in);
      rd_check(OFS_STATUS2, exp_status(p));
    end
    axi_write(OFS_STATUS2, 32'h0000_ffff, r);
    check({30'h0, r}, {30'h0, RESP_OKAY});
    rd_check(OFS_STATUS2, 32'h0000_9fcd);
    @(posedge mclk_in);
    pins <= 11'h000;
    repeat (10) @(posedge mclk_in);
    rd_check(OFS_STATUS2, 32'h0000_0020);
  endtask : test_status_walk

  task automatic test_unmapped();
    logic [31:0] d;
    logic [1:0]  r;
    axi_read(8'h10, d, r);
    check({30'h0, r}, {30'h0, RESP_SLVERR});
    check(d, 32'h0);
    axi_write(8'h10, 32'hffff_ffff, r);
    check({30'h0, r}, {30'h0, RESP_SLVERR});
  endtask : test_unmapped

  task automatic test_irq();
    logic [1:0] r;
    axi_write(OFS_IRQ_STATUS, 32'hf, r);
    rd_check(OFS_IRQ_STATUS, 32'h0);
    @(posedge mclk_in);
    pins <= 11'h008;
    repeat (10) @(posedge mclk_in);
    rd_check(OFS_IRQ_STATUS, 32'h2);
    check({31'h0, irq}, 32'h0);
    axi_write(OFS_IRQ_MASK, 32'h2, r);
    repeat (3) @(posedge mclk_in);
    check({31'h0, irq}, 32'h1);
    axi_write(OFS_IRQ_STATUS, 32'h2, r);
    repeat (3) @(posedge mclk_in);
    check({31'h0, irq}, 32'h0);
    rd_check(OFS_IRQ_STATUS, 32'h0);
    @(posedge mclk_in);
    pins <= 11'h000;
    repeat (10) @(posedge mclk_in);
  endtask : test_irq

  // a loss while the notice is disabled must not queue one, so exactly one notice goes out
  task automatic test_notice();
    logic [1:0]   r;
    string        msg;
    int           n;
    msg = "Line Loss Detected\r\n";
    axi_write(OFS_IRQ_MASK, 32'h0, r);
    axi_write(OFS_IRQ_STATUS, 32'hf, r);
    axi_write(OFS_CONTROL, 32'h1, r);
    check({26'h0, rx_count}, 32'h0);
    @(posedge mclk_in);
    pins <= 11'h001;
    n = 0;
    while (rx_count < 6'd20 && n < 4000) begin
      @(posedge mclk_in);
      n++;
    end
    repeat (4 * BC * 10) @(posedge mclk_in);
    check({26'h0, rx_count}, 32'd20);
    check({26'h0, frame_err}, 32'h0);
    for (int i = 0; i < 20; i++) check({24'h0, rx_buf[i]}, {24'h0, msg[i]});
    check({31'h0, txd}, 32'h1);
    rd_check(OFS_IRQ_STATUS, 32'h9);
  endtask : test_notice

  initial begin
    repeat (12) @(posedge mclk_in);
    rst_b_in <= 1'b1;
    @(posedge mclk_in);
    test_reset_values();
    test_status_walk();
    test_unmapped();
    test_irq();
    test_notice();
    give_verdict();
  end

  initial begin
    repeat (30000) @(posedge mclk_in);
    n_mismatch++;
    give_verdict();
  end
endmodule : usw_status_word2_reporter_bench
